/* ref_dac_pkg.sv */
// Constants and carrier types for the ladder reference converter control
package ref_dac_pkg;

  localparam int        REG_ADDR_W         = 4;
  localparam logic [3:0] CONTROL_OFFSET    = 4'h0;
  localparam logic [3:0] LEVEL_OFFSET      = 4'h1;

  localparam int        ENABLE_BIT         = 7;
  localparam int        PIN1_OE_BIT        = 5;
  localparam int        PIN2_OE_BIT        = 4;
  localparam int        PSS_LSB            = 2;
  localparam int        NSS_BIT            = 0;
  localparam int        LEVEL_W            = 5;
  localparam int        TAP_COUNT          = 32;
  localparam int        PIN_COUNT          = 2;

  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hbd;
  localparam logic [7:0] LEVEL_WRITE_MASK   = 8'h1f;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] LEVEL_RESET        = 8'h00;

  localparam logic [1:0] PSS_SUPPLY         = 2'h0;
  localparam logic [1:0] PSS_EXT_PIN        = 2'h1;
  localparam logic [1:0] PSS_FIXED_REF      = 2'h2;

  typedef struct packed {
    logic       converter_enable;
    logic       pin1_level_out_enable;
    logic       pin2_level_out_enable;
    logic [1:0] positive_ref_select;
    logic       negative_ref_select;
  } control_t;

  typedef struct packed {
    logic                   ladder_on;
    logic [TAP_COUNT-1:0]   tap_select;
    logic                   pos_supply;
    logic                   pos_ext_pin;
    logic                   pos_fixed_ref;
    logic                   neg_ext_pin;
    logic                   neg_ground;
  } ladder_switch_t;

  typedef struct packed {
    logic drive_out;
    logic drive_oe;
    logic pullup_en;
  } pad_ctrl_t;

endpackage

/* level_pin_override.sv */
// One output pin shared between port logic and the converter level
`timescale 1ns/1ps
`default_nettype none

module level_pin_override (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  connect_d,
  input  wire ref_dac_pkg::pad_ctrl_t gpio_req,
  input  wire logic                  pad_in,
  output ref_dac_pkg::pad_ctrl_t     pad_drive,
  output logic                       pin_read,
  output logic                       level_connect
);

  // Connect follows the control register's next value, so the pin hands over on the write edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      level_connect <= 1'b0;
    end else begin
      level_connect <= connect_d;
    end
  end

  // Driver, threshold detector and pull-up all lose the pin while the level owns it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pad_drive <= '0;
    end else if (connect_d) begin
      pad_drive <= '0;
    end else begin
      pad_drive <= gpio_req;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_read <= 1'b0;
    end else begin
      pin_read <= connect_d ? 1'b0 : pad_in;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_pin_driver_released;
    level_connect |-> !pad_drive.drive_oe && !pad_drive.pullup_en && !pad_drive.drive_out;
  endproperty
  a_pin_driver_released: assert property (p_pin_driver_released)
    else $error("pin driver or pull-up active while level connected");

  property p_pin_reads_zero;
    level_connect |-> !pin_read;
  endproperty
  a_pin_reads_zero: assert property (p_pin_reads_zero)
    else $error("connected pin read back nonzero");

  property p_pin_passes_when_free;
    !connect_d |=> pin_read == $past(pad_in) && pad_drive == $past(gpio_req);
  endproperty
  a_pin_passes_when_free: assert property (p_pin_passes_when_free)
    else $error("free pin not returned to port logic");

endmodule

`default_nettype wire

/* ref_ladder_dac_control.sv */
// Control logic of the 5-bit resistor-ladder reference converter
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ref_ladder_dac_control #(
  parameter int ADDR_W = ref_dac_pkg::REG_ADDR_W
) (
  input  wire logic                                         mclk,
  input  wire logic                                         resetn,
  input  wire logic [ADDR_W-1:0]                            reg_addr,
  input  wire logic [7:0]                                   reg_wdata,
  input  wire logic                                         reg_wr,
  input  wire logic                                         reg_rd,
  output logic      [7:0]                                   reg_rdata,
  input  wire logic                                         sleep_mode,
  input  wire ref_dac_pkg::pad_ctrl_t [ref_dac_pkg::PIN_COUNT-1:0] gpio_req,
  input  wire logic [ref_dac_pkg::PIN_COUNT-1:0]            pad_in,
  output ref_dac_pkg::pad_ctrl_t [ref_dac_pkg::PIN_COUNT-1:0] pad_drive,
  output logic      [ref_dac_pkg::PIN_COUNT-1:0]            pin_read,
  output logic      [ref_dac_pkg::PIN_COUNT-1:0]            level_out_connect,
  output ref_dac_pkg::ladder_switch_t                       ladder_sw
);

  ref_dac_pkg::control_t               control_q;
  ref_dac_pkg::control_t               control_d;
  logic [ref_dac_pkg::LEVEL_W-1:0]     level_code_q;
  logic [ref_dac_pkg::LEVEL_W-1:0]     level_code_d;
  logic                                control_wr;
  logic                                level_wr;
  logic [7:0]                          control_view;
  logic [7:0]                          level_view;
  logic [7:0]                          wdata_ctrl;
  logic [ref_dac_pkg::PIN_COUNT-1:0]   connect_d;
  ref_dac_pkg::ladder_switch_t         ladder_sw_d;

  assign control_wr = reg_wr && (reg_addr == ADDR_W'(ref_dac_pkg::CONTROL_OFFSET));
  assign level_wr   = reg_wr && (reg_addr == ADDR_W'(ref_dac_pkg::LEVEL_OFFSET));
  assign wdata_ctrl = reg_wdata & ref_dac_pkg::CONTROL_WRITE_MASK;

  // Next register state; hardware never touches these, so Sleep and wake leave them alone
  always_comb begin
    control_d = control_q;
    if (control_wr) begin
      control_d.converter_enable      = wdata_ctrl[ref_dac_pkg::ENABLE_BIT];
      control_d.pin1_level_out_enable = wdata_ctrl[ref_dac_pkg::PIN1_OE_BIT];
      control_d.pin2_level_out_enable = wdata_ctrl[ref_dac_pkg::PIN2_OE_BIT];
      control_d.positive_ref_select   = wdata_ctrl[ref_dac_pkg::PSS_LSB +: 2];
      control_d.negative_ref_select   = wdata_ctrl[ref_dac_pkg::NSS_BIT];
    end
  end

  always_comb begin
    level_code_d = level_code_q;
    if (level_wr) begin
      level_code_d = reg_wdata[ref_dac_pkg::LEVEL_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      control_q <= ref_dac_pkg::control_t'(ref_dac_pkg::CONTROL_RESET[5:0]);
    end else begin
      control_q <= control_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      level_code_q <= ref_dac_pkg::LEVEL_RESET[ref_dac_pkg::LEVEL_W-1:0];
    end else begin
      level_code_q <= level_code_d;
    end
  end

  // Switches decode from the next state so a write lands on its own edge
  always_comb begin
    ladder_sw_d = '0;
    if (control_d.converter_enable) begin
      ladder_sw_d.ladder_on                 = 1'b1;
      ladder_sw_d.tap_select[level_code_d]  = 1'b1;
      // Reserved positive code opens every positive source switch rather than shorting two
      ladder_sw_d.pos_supply    = control_d.positive_ref_select == ref_dac_pkg::PSS_SUPPLY;
      ladder_sw_d.pos_ext_pin   = control_d.positive_ref_select == ref_dac_pkg::PSS_EXT_PIN;
      ladder_sw_d.pos_fixed_ref = control_d.positive_ref_select == ref_dac_pkg::PSS_FIXED_REF;
      ladder_sw_d.neg_ext_pin   = control_d.negative_ref_select;
      ladder_sw_d.neg_ground    = !control_d.negative_ref_select;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ladder_sw <= '0;
    end else begin
      ladder_sw <= ladder_sw_d;
    end
  end

  assign connect_d[0] = control_d.pin1_level_out_enable;
  assign connect_d[1] = control_d.pin2_level_out_enable;

  generate
    for (genvar p = 0; p < ref_dac_pkg::PIN_COUNT; p++) begin : g_pin
      level_pin_override u_pin (
        .mclk          (mclk),
        .resetn        (resetn),
        .connect_d     (connect_d[p]),
        .gpio_req      (gpio_req[p]),
        .pad_in        (pad_in[p]),
        .pad_drive     (pad_drive[p]),
        .pin_read      (pin_read[p]),
        .level_connect (level_out_connect[p])
      );
    end
  endgenerate

  // Read views: unimplemented bits are simply never placed
  always_comb begin
    control_view = 8'h00;
    control_view[ref_dac_pkg::ENABLE_BIT]    = control_q.converter_enable;
    control_view[ref_dac_pkg::PIN1_OE_BIT]   = control_q.pin1_level_out_enable;
    control_view[ref_dac_pkg::PIN2_OE_BIT]   = control_q.pin2_level_out_enable;
    control_view[ref_dac_pkg::PSS_LSB +: 2]  = control_q.positive_ref_select;
    control_view[ref_dac_pkg::NSS_BIT]       = control_q.negative_ref_select;
    level_view = {3'h0, level_code_q};
  end

  // Unmapped addresses and idle cycles read as zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == ADDR_W'(ref_dac_pkg::CONTROL_OFFSET)) begin
      reg_rdata <= control_view;
    end else if (reg_rd && reg_addr == ADDR_W'(ref_dac_pkg::LEVEL_OFFSET)) begin
      reg_rdata <= level_view;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_enable_write;
    control_wr && reg_wdata[ref_dac_pkg::ENABLE_BIT];
  endsequence

  sequence s_quiet_wake;
    (sleep_mode && !control_wr) ##1 (!sleep_mode && !control_wr);
  endsequence

  sequence s_level_write_enabled;
    level_wr && !control_wr && control_q.converter_enable;
  endsequence

  property p_enable_on_write;
    s_enable_write |=> ladder_sw.ladder_on && ladder_sw.tap_select != '0;
  endproperty
  a_enable_on_write: assert property (p_enable_on_write)
    else $error("enable write did not start converter");

  property p_idle_when_disabled;
    !control_q.converter_enable |-> ladder_sw == '0;
  endproperty
  a_idle_when_disabled: assert property (p_idle_when_disabled)
    else $error("switches closed while converter disabled");

  property p_one_tap;
    ladder_sw.ladder_on |-> ladder_sw.tap_select == (32'h1 << level_code_q);
  endproperty
  a_one_tap: assert property (p_one_tap)
    else $error("tap select does not match level code");

  property p_pin_connect;
    control_wr |=> level_out_connect == {$past(reg_wdata[ref_dac_pkg::PIN2_OE_BIT]),
                                         $past(reg_wdata[ref_dac_pkg::PIN1_OE_BIT])};
  endproperty
  a_pin_connect: assert property (p_pin_connect)
    else $error("pin connect not following control write");

  property p_positive_source;
    ladder_sw.ladder_on |->
      ladder_sw.pos_supply == (control_q.positive_ref_select == 2'h0) &&
      ladder_sw.pos_ext_pin == (control_q.positive_ref_select == 2'h1) &&
      ladder_sw.pos_fixed_ref == (control_q.positive_ref_select == 2'h2);
  endproperty
  a_positive_source: assert property (p_positive_source)
    else $error("positive source switch wrong");

  property p_negative_source;
    ladder_sw.ladder_on |->
      ladder_sw.neg_ext_pin == control_q.negative_ref_select &&
      ladder_sw.neg_ground != control_q.negative_ref_select;
  endproperty
  a_negative_source: assert property (p_negative_source)
    else $error("negative source switch wrong");

  property p_wake_keeps_control;
    s_quiet_wake |=> control_q == $past(control_q, 2);
  endproperty
  a_wake_keeps_control: assert property (p_wake_keeps_control)
    else $error("control register changed across wake");

  property p_reset_clears;
    disable iff (1'b0)
    !resetn |=> control_q == '0 && level_code_q == '0 && ladder_sw == '0 && level_out_connect == '0;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset left converter state behind");

  // Bits 6 and 1 are unused in the control view; the level view uses bit 1 and leaves bits 7 to 5 unused
  property p_reserved_read_zero;
    reg_rd |=>
      ($past(reg_addr) != ADDR_W'(ref_dac_pkg::CONTROL_OFFSET) ||
       (reg_rdata[6] == 1'b0 && reg_rdata[1] == 1'b0)) &&
      ($past(reg_addr) != ADDR_W'(ref_dac_pkg::LEVEL_OFFSET) || reg_rdata[7:5] == 3'h0);
  endproperty
  a_reserved_read_zero: assert property (p_reserved_read_zero)
    else $error("unimplemented bit read nonzero");

  property p_level_same_edge;
    s_level_write_enabled |=> ladder_sw.tap_select == (32'h1 << $past(reg_wdata[4:0]));
  endproperty
  a_level_same_edge: assert property (p_level_same_edge)
    else $error("level write not applied on its edge");

  // Readback is checked over write, gap, read; back-to-back pairs rely on the holds below
  sequence s_control_write_then_read;
    control_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == ADDR_W'(ref_dac_pkg::CONTROL_OFFSET));
  endsequence

  sequence s_level_write_then_read;
    level_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == ADDR_W'(ref_dac_pkg::LEVEL_OFFSET));
  endsequence

  property p_control_readback;
    s_control_write_then_read |=> reg_rdata == ($past(reg_wdata, 3) & ref_dac_pkg::CONTROL_WRITE_MASK);
  endproperty
  a_control_readback: assert property (p_control_readback)
    else $error("control readback differs from masked write");

  property p_level_readback;
    s_level_write_then_read |=> reg_rdata == {3'h0, $past(reg_wdata[ref_dac_pkg::LEVEL_W-1:0], 3)};
  endproperty
  a_level_readback: assert property (p_level_readback)
    else $error("level readback differs from write");

  property p_rdata_idle_zero;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle_zero: assert property (p_rdata_idle_zero)
    else $error("read data present without a read");

  property p_disable_on_write;
    control_wr && !reg_wdata[ref_dac_pkg::ENABLE_BIT] |=> ladder_sw == '0;
  endproperty
  a_disable_on_write: assert property (p_disable_on_write)
    else $error("disable write left switches closed");

  property p_level_while_disabled;
    level_wr && !control_wr && !control_q.converter_enable |=>
      ladder_sw == '0 && level_code_q == $past(reg_wdata[ref_dac_pkg::LEVEL_W-1:0]);
  endproperty
  a_level_while_disabled: assert property (p_level_while_disabled)
    else $error("level write while disabled closed a switch or was lost");

  // Refused writes must not disturb either register
  property p_unmapped_write_ignored;
    reg_wr && reg_addr != ADDR_W'(ref_dac_pkg::CONTROL_OFFSET) &&
      reg_addr != ADDR_W'(ref_dac_pkg::LEVEL_OFFSET) |=>
      control_q == $past(control_q) && level_code_q == $past(level_code_q);
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored)
    else $error("unmapped write changed a register");

  property p_control_holds;
    !control_wr |=> control_q == $past(control_q);
  endproperty
  a_control_holds: assert property (p_control_holds)
    else $error("control register changed without a write");

  property p_level_holds;
    !level_wr |=> level_code_q == $past(level_code_q);
  endproperty
  a_level_holds: assert property (p_level_holds)
    else $error("level code changed without a write");

  property p_connect_holds;
    !control_wr |=> level_out_connect == $past(level_out_connect);
  endproperty
  a_connect_holds: assert property (p_connect_holds)
    else $error("pin connect changed without a write");

  property p_switches_hold;
    !control_wr && !level_wr |=> ladder_sw == $past(ladder_sw);
  endproperty
  a_switches_hold: assert property (p_switches_hold)
    else $error("ladder switches moved without a write");

  // Two closed positive switches would short two references together
  property p_single_positive_source;
    ladder_sw.ladder_on |-> $onehot0({ladder_sw.pos_supply, ladder_sw.pos_ext_pin, ladder_sw.pos_fixed_ref});
  endproperty
  a_single_positive_source: assert property (p_single_positive_source)
    else $error("more than one positive source closed");

  property p_single_tap;
    ladder_sw.ladder_on |-> $onehot(ladder_sw.tap_select);
  endproperty
  a_single_tap: assert property (p_single_tap)
    else $error("ladder tap select not one-hot");

  property p_source_same_edge;
    control_wr && reg_wdata[ref_dac_pkg::ENABLE_BIT] |=>
      ladder_sw.pos_fixed_ref == ($past(reg_wdata[ref_dac_pkg::PSS_LSB +: 2]) == ref_dac_pkg::PSS_FIXED_REF) &&
      ladder_sw.pos_ext_pin == ($past(reg_wdata[ref_dac_pkg::PSS_LSB +: 2]) == ref_dac_pkg::PSS_EXT_PIN);
  endproperty
  a_source_same_edge: assert property (p_source_same_edge)
    else $error("source write not applied on its edge");

  property p_negative_same_edge;
    control_wr && reg_wdata[ref_dac_pkg::ENABLE_BIT] |=>
      ladder_sw.neg_ext_pin == $past(reg_wdata[ref_dac_pkg::NSS_BIT]);
  endproperty
  a_negative_same_edge: assert property (p_negative_same_edge)
    else $error("negative source write not applied on its edge");

  property p_reset_read_zero;
    disable iff (1'b0)
    !resetn |=> reg_rdata == 8'h00 && pad_drive == '0 && pin_read == '0;
  endproperty
  a_reset_read_zero: assert property (p_reset_read_zero)
    else $error("reset left read data or pad outputs behind");

endmodule

`default_nettype wire

/* ref_ladder_dac_control_tb.sv */
// Self-checking testbench for the ladder reference converter control block
`timescale 1ns/1ps
`default_nettype none

module ref_ladder_dac_control_tb;
  logic                                                   mclk;
  logic                                                   resetn;
  logic [3:0]                                             reg_addr;
  logic [7:0]                                             reg_wdata;
  logic                                                   reg_wr;
  logic                                                   reg_rd;
  logic [7:0]                                             reg_rdata;
  logic                                                   sleep_mode;
  ref_dac_pkg::pad_ctrl_t [ref_dac_pkg::PIN_COUNT-1:0]    gpio_req;
  logic [ref_dac_pkg::PIN_COUNT-1:0]                      pad_in;
  ref_dac_pkg::pad_ctrl_t [ref_dac_pkg::PIN_COUNT-1:0]    pad_drive;
  logic [ref_dac_pkg::PIN_COUNT-1:0]                      pin_read;
  logic [ref_dac_pkg::PIN_COUNT-1:0]                      level_out_connect;
  ref_dac_pkg::ladder_switch_t                            ladder_sw;
  int                                                     failures;
  int                                                     checks;
  logic [7:0]                                             ctl;

  ref_ladder_dac_control #(.ADDR_W(4)) dut_u (
    .mclk              (mclk),
    .resetn            (resetn),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .sleep_mode        (sleep_mode),
    .gpio_req          (gpio_req),
    .pad_in            (pad_in),
    .pad_drive         (pad_drive),
    .pin_read          (pin_read),
    .level_out_connect (level_out_connect),
    .ladder_sw         (ladder_sw)
  );

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_mode = 1'b0;
    gpio_req = {3'h6, 3'h5};
    pad_in = 2'b11;
    failures = 0;
    checks = 0;
  end

  always #2.5 mclk = ~mclk;

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Each access leaves one idle cycle so no strobe is driven twice in a step
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({32'h0, reg_rdata}, {32'h0, exp}, "read data");
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (n) @(posedge mclk);
    resetn <= 1'b1;
    #1;
  endtask

  function automatic ref_dac_pkg::ladder_switch_t exp_sw(input logic [7:0] c, input logic [4:0] l);
    ref_dac_pkg::ladder_switch_t s;
    s = '0;
    if (c[7]) begin
      s.ladder_on = 1'b1;
      s.tap_select = 32'h1 << l;
      s.pos_supply = (c[3:2] == 2'h0);
      s.pos_ext_pin = (c[3:2] == 2'h1);
      s.pos_fixed_ref = (c[3:2] == 2'h2);
      s.neg_ext_pin = c[0];
      s.neg_ground = ~c[0];
    end
    return s;
  endfunction

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk(40'(ladder_sw), 40'h0, "switches after reset");
    rd_chk(ref_dac_pkg::CONTROL_OFFSET, 8'h00);
    rd_chk(ref_dac_pkg::LEVEL_OFFSET, 8'h00);
    // Unused bits and unmapped address; positive code kept off the reserved value
    wr_reg(ref_dac_pkg::CONTROL_OFFSET, 8'hf7);
    rd_chk(ref_dac_pkg::CONTROL_OFFSET, 8'hb5);
    wr_reg(ref_dac_pkg::LEVEL_OFFSET, 8'hff);
    rd_chk(ref_dac_pkg::LEVEL_OFFSET, 8'h1f);
    wr_reg(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00);
    rd_chk(ref_dac_pkg::CONTROL_OFFSET, 8'hb5);
    // Every tap, enabled, supply source and ground
    ctl = 8'h80;
    wr_reg(ref_dac_pkg::CONTROL_OFFSET, ctl);
    for (int i = 0; i < 32; i++) begin
      wr_reg(ref_dac_pkg::LEVEL_OFFSET, 8'(i));
      chk(40'(ladder_sw), 40'(exp_sw(ctl, 5'(i))), "tap select");
    end
    rd_chk(ref_dac_pkg::LEVEL_OFFSET, 8'h1f);
    // Every legal source combination
    for (int p = 0; p < 3; p++) begin
      for (int n = 0; n < 2; n++) begin
        ctl = {1'b1, 3'b000, 2'(p), 1'b0, 1'(n)};
        wr_reg(ref_dac_pkg::CONTROL_OFFSET, ctl);
        chk(40'(ladder_sw), 40'(exp_sw(ctl, 5'h1f)), "source switches");
      end
    end
    wr_reg(ref_dac_pkg::CONTROL_OFFSET, 8'h09);
    chk(40'(ladder_sw), 40'h0, "disabled switches");
    // Pins free: digital path passes through
    @(posedge mclk);
    #1;
    chk(40'(pin_read), 40'h3, "free pin read");
    chk(40'(pad_drive), 40'(6'h35), "free pad drive");
    wr_reg(ref_dac_pkg::CONTROL_OFFSET, 8'h20);
    chk(40'(level_out_connect), 40'h1, "pin a connect");
    @(posedge mclk);
    #1;
    chk(40'(pin_read), 40'h2, "pin a read");
    chk(40'(pad_drive), 40'(6'h30), "pin a pad");
    wr_reg(ref_dac_pkg::CONTROL_OFFSET, 8'h10);
    chk(40'(level_out_connect), 40'h2, "pin b connect");
    @(posedge mclk);
    #1;
    chk(40'(pin_read), 40'h1, "pin b read");
    chk(40'(pad_drive), 40'(6'h05), "pin b pad");
    // Sleep keeps everything running and stored
    ctl = 8'hb5;
    wr_reg(ref_dac_pkg::CONTROL_OFFSET, ctl);
    @(posedge mclk);
    sleep_mode <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    chk(40'(ladder_sw), 40'(exp_sw(ctl, 5'h1f)), "sleep switches");
    @(posedge mclk);
    sleep_mode <= 1'b0;
    rd_chk(ref_dac_pkg::CONTROL_OFFSET, ctl);
    chk(40'(level_out_connect), 40'h3, "sleep pins");
    // Reset in mid-run clears it all
    do_reset(2);
    chk(40'(ladder_sw), 40'h0, "switches after second reset");
    chk(40'(level_out_connect), 40'h0, "pins after second reset");
    rd_chk(ref_dac_pkg::LEVEL_OFFSET, 8'h00);
    rd_chk(ref_dac_pkg::CONTROL_OFFSET, 8'h00);
    // Level stored while disabled, switches stay open
    wr_reg(ref_dac_pkg::LEVEL_OFFSET, 8'h0a);
    chk(40'(ladder_sw), 40'h0, "level write while disabled");
    rd_chk(ref_dac_pkg::LEVEL_OFFSET, 8'h0a);
    report_and_stop();
  end
endmodule

`default_nettype wire
